// file: core/spfe_regs.svh
`ifndef SPFE_REGS_SVH
`define SPFE_REGS_SVH

// Command opcodes.
`define SPFE_OP_PROG        8'h02
`define SPFE_OP_DUAL_PROG   8'hA2
`define SPFE_OP_ERASE_4K    8'h20
`define SPFE_OP_ERASE_32K   8'h52
`define SPFE_OP_ERASE_64K   8'hD8
`define SPFE_OP_CHIP_A      8'h60
`define SPFE_OP_CHIP_B      8'hC7

// Frame framing: one opcode byte, then three address bytes.
`define SPFE_OPC_BYTES      3'h1
`define SPFE_HDR_BYTES      3'h4
`define SPFE_LAST_ADDR_BYTE 3'h3
`define SPFE_PAGE_BYTES     9'h100
`define SPFE_ONE_BYTE       9'h001

// Ignored low address bits for each block size.
`define SPFE_MASK_4K        24'h00_0FFF
`define SPFE_MASK_32K       24'h00_7FFF
`define SPFE_MASK_64K       24'h00_FFFF
`define SPFE_SECTOR_LSB     16

// Core clock rate and self-timed cycle durations in microseconds.
`define SPFE_CLK_MHZ            50
`define SPFE_BYTE_PROG_US       10
`define SPFE_PAGE_PROG_US       1000
`define SPFE_BLOCK_ERASE_US     100000
`define SPFE_FULL_ERASE_US      1000000

`endif

// file: core/spfe_pkg.sv
package spfe_pkg;

	typedef enum logic [2:0] {
		SPFE_MEM_PROG,
		SPFE_MEM_ERASE_4K,
		SPFE_MEM_ERASE_32K,
		SPFE_MEM_ERASE_64K,
		SPFE_MEM_ERASE_ALL
	} spfe_memop_t;

	typedef enum logic [1:0] {
		SPFE_IDLE,
		SPFE_PROG,
		SPFE_ERASE,
		SPFE_WAIT
	} spfe_state_t;

endpackage : spfe_pkg

// file: core/spfe_ctrl.sv
`timescale 1ns/1ns
`include "spfe_regs.svh"

module spfe_ctrl
	import spfe_pkg::*;
#(
	parameter int unsigned NUM_SECTORS    = 32,
	parameter int unsigned BYTE_PROG_CYC  = `SPFE_BYTE_PROG_US * `SPFE_CLK_MHZ,
	parameter int unsigned PAGE_PROG_CYC  = `SPFE_PAGE_PROG_US * `SPFE_CLK_MHZ,
	parameter int unsigned BLOCK_ERASE_CYC = `SPFE_BLOCK_ERASE_US * `SPFE_CLK_MHZ,
	parameter int unsigned FULL_ERASE_CYC = `SPFE_FULL_ERASE_US * `SPFE_CLK_MHZ
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   si,
	input  wire logic                   dualUpperBitPin,
	input  wire logic                   writeEnableSet,
	input  wire logic [NUM_SECTORS-1:0] sectorProtect,
	input  wire logic [NUM_SECTORS-1:0] sectorLock,
	input  wire logic                   memFault,
	output logic                        busy,
	output logic                        writeEnableLatch,
	output logic                        programEraseErrorFlag,
	output logic                        memStrobe,
	output spfe_memop_t                 memOp,
	output logic [23:0]                 memAddr,
	output logic [7:0]                  memData
);

	localparam int unsigned SEC_W = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;

	// The page walk takes one cycle per location, so both program durations must outlast it.
	if (NUM_SECTORS < 1 || NUM_SECTORS > 256)
		$error("spfe_ctrl: NUM_SECTORS must lie in 1..256");
	if (BYTE_PROG_CYC < 300 || PAGE_PROG_CYC < 300 || BLOCK_ERASE_CYC < 2 || FULL_ERASE_CYC < 2)
		$error("spfe_ctrl: cycle durations too short for the page walk");

	// ------------------------------------------------------------------
	// Link domain, clocked by sclk while chip select is low.
	// ------------------------------------------------------------------
	logic        fresh;
	logic        busyL1;
	logic        busyL2;
	logic [2:0]  linkPh;
	logic [2:0]  linkBytes;
	logic [7:0]  linkShift;
	logic [7:0]  linkOp;
	logic [23:0] linkAddr;
	logic [7:0]  linkPtr;
	logic [8:0]  linkCount;
	logic [255:0] linkMask;
	logic [7:0]  pageBuf [0:255];

	// Fresh is forced high while deselected, so the first edge of a frame restarts
	// the counters without clearing what the core still has to read at release.
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n)
			fresh <= 1'b1;
		else
			fresh <= 1'b0;
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			busyL1 <= 1'b0;
			busyL2 <= 1'b0;
		end else begin
			busyL1 <= busy;
			busyL2 <= busyL1;
		end
	end

	wire [2:0] curPh     = fresh ? 3'h0 : linkPh;
	wire [2:0] curBytes  = fresh ? 3'h0 : linkBytes;
	wire       isProgOpL = (linkOp == `SPFE_OP_PROG) || (linkOp == `SPFE_OP_DUAL_PROG);
	wire       dualNow   = (curBytes == `SPFE_HDR_BYTES) && (linkOp == `SPFE_OP_DUAL_PROG);
	wire [7:0] shNext    = dualNow ? {linkShift[5:0], dualUpperBitPin, si}
	                               : {linkShift[6:0], si};
	wire [2:0] phNext    = curPh + (dualNow ? 3'h2 : 3'h1);
	wire       byteDone  = (phNext == 3'h0);
	wire       hdrByte   = byteDone && (curBytes != `SPFE_HDR_BYTES);
	wire [2:0] next_linkBytes = hdrByte ? curBytes + 3'h1 : curBytes;
	// Data is stored only behind a full header and never while a cycle uses the buffer.
	wire       storeData = byteDone && (curBytes == `SPFE_HDR_BYTES) && isProgOpL && !busyL2;
	wire [8:0] next_linkCount = (linkCount == `SPFE_PAGE_BYTES) ? linkCount
	                                                            : linkCount + 9'h001;

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			linkPh    <= 3'h0;
			linkBytes <= 3'h0;
			linkShift <= 8'h00;
		end else begin
			linkPh    <= phNext;
			linkBytes <= next_linkBytes;
			linkShift <= shNext;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			linkOp   <= 8'h00;
			linkAddr <= 24'h00_0000;
		end else if (hdrByte) begin
			if (curBytes == 3'h0)
				linkOp <= shNext;
			else
				linkAddr <= {linkAddr[15:0], shNext};
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			linkPtr   <= 8'h00;
			linkCount <= 9'h000;
			linkMask  <= '0;
		end else begin
			// Cleared on every fresh frame: the core has already copied what it needs at
			// start, and a stale busy view after polling must not keep an old mask.
			if (fresh) begin
				linkCount <= 9'h000;
				linkMask  <= '0;
			end
			if (hdrByte && curBytes == `SPFE_LAST_ADDR_BYTE)
				linkPtr <= shNext;
			if (storeData) begin
				linkPtr           <= linkPtr + 8'h01;
				linkMask[linkPtr] <= 1'b1;
				linkCount         <= next_linkCount;
			end
		end
	end

	// Later bytes overwrite earlier ones at a wrapped pointer, keeping the last page.
	always_ff @(posedge sclk) begin
		if (storeData)
			pageBuf[linkPtr] <= shNext;
	end

	// ------------------------------------------------------------------
	// Core domain.
	// ------------------------------------------------------------------
	logic csS1;
	logic csS2;
	logic csS3;
	logic csState;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			csS1 <= 1'b1;
			csS2 <= 1'b1;
			csS3 <= 1'b1;
		end else begin
			csS1 <= cs_n;
			csS2 <= csS1;
			csS3 <= csS2;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			csState <= 1'b1;
		else if (csS2 && csS3)
			csState <= 1'b1;
		else if (!csS2 && !csS3)
			csState <= 1'b0;
	end

	// The link registers are quiet once sclk stops at release, so they are read here
	// as static words; the host must not clock while deselected.
	wire csRise    = !csState && csS2 && csS3;
	wire frameEnd  = csRise && !busy;
	wire aligned   = (linkPh == 3'h0);
	wire opValid   = (linkBytes >= `SPFE_OPC_BYTES);
	wire hdrFull   = (linkBytes == `SPFE_HDR_BYTES);
	wire [SEC_W-1:0] secIdx = linkAddr[`SPFE_SECTOR_LSB +: SEC_W];
	wire secInRange = ({24'h00_0000, linkAddr[23:`SPFE_SECTOR_LSB]} < 32'(NUM_SECTORS));
	wire secBlocked = secInRange && (sectorProtect[secIdx] || sectorLock[secIdx]);
	wire anyBlocked = |(sectorProtect | sectorLock);

	wire isProg  = opValid && ((linkOp == `SPFE_OP_PROG) || (linkOp == `SPFE_OP_DUAL_PROG));
	wire is4k    = opValid && (linkOp == `SPFE_OP_ERASE_4K);
	wire is32k   = opValid && (linkOp == `SPFE_OP_ERASE_32K);
	wire is64k   = opValid && (linkOp == `SPFE_OP_ERASE_64K);
	wire isBlock = is4k || is32k || is64k;
	wire isChip  = opValid && ((linkOp == `SPFE_OP_CHIP_A) || (linkOp == `SPFE_OP_CHIP_B));

	wire progFrameOk  = aligned && hdrFull && (linkCount != 9'h000);
	wire progOk       = isProg && progFrameOk && !secBlocked;
	wire blockOk      = isBlock && aligned && hdrFull && !secBlocked;
	wire chipOk       = isChip && aligned && !anyBlocked;
	wire progAbort    = frameEnd && isProg && !progOk;
	wire blockAbort   = frameEnd && isBlock && !blockOk;
	wire chipAbort    = frameEnd && isChip && !chipOk;
	wire abortClear   = progAbort || blockAbort || chipAbort;
	// An erase or program runs only with the latch set beforehand.
	wire startProg    = frameEnd && progOk && writeEnableLatch;
	wire startErase   = frameEnd && (blockOk || chipOk) && writeEnableLatch;
	wire startAny     = startProg || startErase;

	wire [23:0] eraseMask = is4k  ? `SPFE_MASK_4K :
	                        is32k ? `SPFE_MASK_32K :
	                                `SPFE_MASK_64K;
	wire [23:0] eraseAddr = isChip ? 24'h00_0000 : (linkAddr & ~eraseMask);
	wire spfe_memop_t eraseOp = isChip ? SPFE_MEM_ERASE_ALL :
	                            is4k   ? SPFE_MEM_ERASE_4K :
	                            is32k  ? SPFE_MEM_ERASE_32K :
	                                     SPFE_MEM_ERASE_64K;
	wire [31:0] progDur  = (linkCount == `SPFE_ONE_BYTE) ? 32'(BYTE_PROG_CYC)
	                                                     : 32'(PAGE_PROG_CYC);
	wire [31:0] eraseDur = isChip ? 32'(FULL_ERASE_CYC) : 32'(BLOCK_ERASE_CYC);

	spfe_state_t  state;
	logic [31:0]  timer;
	logic [8:0]   stepIdx;
	logic [255:0] maskCopy;
	logic [15:0]  pageBase;
	logic         faultArm;

	wire [7:0] stepPos   = stepIdx[7:0];
	wire       walkDone  = (stepIdx == `SPFE_PAGE_BYTES);
	wire       stepWrite = (state == SPFE_PROG) && !walkDone && maskCopy[stepPos];
	wire       timeUp    = (state == SPFE_WAIT) && (timer == 32'h0000_0000);
	wire       eraseFail = timeUp && (memOp != SPFE_MEM_PROG) && memFault;
	wire       progFail  = faultArm && memFault;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SPFE_IDLE;
		end else begin
			unique case (state)
				SPFE_IDLE: begin
					if (startProg)
						state <= SPFE_PROG;
					else if (startErase)
						state <= SPFE_ERASE;
				end
				SPFE_PROG: begin
					if (walkDone)
						state <= SPFE_WAIT;
				end
				SPFE_ERASE: state <= SPFE_WAIT;
				SPFE_WAIT: begin
					if (timeUp)
						state <= SPFE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer    <= 32'h0000_0000;
			stepIdx  <= 9'h000;
			maskCopy <= '0;
			pageBase <= 16'h0000;
		end else if (startProg) begin
			timer    <= progDur;
			stepIdx  <= 9'h000;
			maskCopy <= linkMask;
			pageBase <= linkAddr[23:8];
		end else if (startErase) begin
			timer <= eraseDur;
		end else begin
			if (timer != 32'h0000_0000)
				timer <= timer - 32'h0000_0001;
			if (state == SPFE_PROG && !walkDone)
				stepIdx <= stepIdx + 9'h001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memStrobe <= 1'b0;
			memOp     <= SPFE_MEM_PROG;
			memAddr   <= 24'h00_0000;
			memData   <= 8'h00;
			faultArm  <= 1'b0;
		end else begin
			memStrobe <= stepWrite || (state == SPFE_ERASE);
			faultArm  <= stepWrite;
			if (startProg)
				memOp <= SPFE_MEM_PROG;
			else if (startErase) begin
				memOp   <= eraseOp;
				memAddr <= eraseAddr;
			end
			if (stepWrite) begin
				memAddr <= {pageBase, stepPos};
				memData <= pageBuf[stepPos];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			busy <= 1'b0;
		else if (startAny)
			busy <= 1'b1;
		else if (timeUp)
			busy <= 1'b0;
	end

	// A new write-enable wins over an abort clear in the same cycle, but cannot
	// reopen the latch once a cycle has started.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			writeEnableLatch <= 1'b0;
		else if (startAny)
			writeEnableLatch <= 1'b0;
		else if (writeEnableSet && !busy)
			writeEnableLatch <= 1'b1;
		else if (abortClear)
			writeEnableLatch <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			programEraseErrorFlag <= 1'b0;
		else if (progFail || eraseFail)
			programEraseErrorFlag <= 1'b1;
		else if (startAny)
			programEraseErrorFlag <= 1'b0;
	end

endmodule : spfe_ctrl

// file: tb/spfe_host_model.sv
`timescale 1ns/1ns
module spfe_host_model (
	output logic sclk,
	output logic cs_n,
	output logic si,
	output logic dualUpperBitPin
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		dualUpperBitPin = 1'b1;
	end

	// Data moves while the clock is low, so each rising edge sees a settled bit.
	task automatic tick(input logic hi, input logic lo);
		#40 sclk = 1'b0;
		dualUpperBitPin = hi;
		si = lo;
		#40 sclk = 1'b1;
	endtask : tick

	// The clock stands low between frames, and released lines show the inverse of
	// their last value so that nothing stale is mistaken for data.
	task automatic frame(input logic [7:0] b[$], input int x, input logic dual);
		#7 cs_n = 1'b0;
		foreach (b[i]) begin
			if (dual && i > 3) begin
				for (int k = 7; k > 0; k -= 2)
					tick(b[i][k], b[i][k - 1]);
			end else begin
				for (int k = 7; k >= 0; k--)
					tick(~dualUpperBitPin, b[i][k]);
			end
		end
		repeat (x) tick(~dualUpperBitPin, ~si);
		#40 sclk = 1'b0;
		cs_n = 1'b1;
		si = ~si;
		dualUpperBitPin = ~dualUpperBitPin;
	endtask : frame
endmodule : spfe_host_model

// file: tb/spfe_ctrl_properties.sv
`timescale 1ns/1ns
module spfe_ctrl_properties
	import spfe_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        memFault,
	input wire logic        busy,
	input wire logic        writeEnableLatch,
	input wire logic        programEraseErrorFlag,
	input wire logic        memStrobe,
	input wire spfe_memop_t memOp,
	input wire logic [23:0] memAddr
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_start;
		$rose(busy);
	endsequence
	sequence s_prog_fault;
		memStrobe && memOp == SPFE_MEM_PROG && memFault;
	endsequence

	a_strobe_in_busy: assert property (memStrobe |-> busy)
		else $error("array strobe while idle");
	a_busy_holds: assert property (s_start |-> busy [*8])
		else $error("busy dropped early");
	a_start_clears_wel: assert property (s_start |-> !writeEnableLatch)
		else $error("latch still set at cycle start");
	a_start_clears_err: assert property (s_start |-> !programEraseErrorFlag)
		else $error("error flag kept at cycle start");
	a_wel_held_low: assert property (busy && !writeEnableLatch |=> !writeEnableLatch)
		else $error("latch set during a cycle");
	a_fault_flagged: assert property (s_prog_fault |=> programEraseErrorFlag)
		else $error("program fault not flagged");
	a_err_sticky: assert property (
		!busy && programEraseErrorFlag |=> programEraseErrorFlag || busy)
		else $error("error flag lost while idle");
	a_mask_4k: assert property (
		memStrobe && memOp == SPFE_MEM_ERASE_4K |-> memAddr[11:0] == 12'h000)
		else $error("small block base not aligned");
	a_mask_32k: assert property (
		memStrobe && memOp == SPFE_MEM_ERASE_32K |-> memAddr[14:0] == 15'h0000)
		else $error("middle block base not aligned");
	a_mask_64k: assert property (
		memStrobe && memOp == SPFE_MEM_ERASE_64K |-> memAddr[15:0] == 16'h0000)
		else $error("large block base not aligned");
endmodule : spfe_ctrl_properties

bind spfe_ctrl spfe_ctrl_properties u_props (.core_clk, .rst_n, .memFault, .busy,
	.writeEnableLatch, .programEraseErrorFlag, .memStrobe, .memOp, .memAddr);

// file: tb/test_spfe_ctrl.sv
`timescale 1ns/1ns
module test_spfe_ctrl
	import spfe_pkg::*;
;
	localparam int BP = 400;
	localparam int PP = 600;
	localparam logic [7:0] EOPC [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
	localparam logic [23:0] EMSK [5] = '{24'hff_f000, 24'hff_8000, 24'hff_0000, 24'h0, 24'h0};
	typedef struct packed {
		spfe_memop_t op;
		logic [23:0] a;
		logic [7:0]  d;
		logic [23:0] m;
	} spfe_exp_t;

	logic        core_clk;
	logic        rst_n;
	logic        writeEnableSet;
	logic        memFault;
	logic [31:0] sectorProtect;
	logic [31:0] sectorLock;
	wire         sclk, cs_n, si, dualUpperBitPin;
	logic        busy, writeEnableLatch, programEraseErrorFlag, memStrobe;
	spfe_memop_t memOp;
	logic [23:0] memAddr, a;
	logic [7:0]  memData, v, gd;
	logic [7:0]  q[$];
	spfe_exp_t   expQ[$];
	spfe_exp_t   e;
	int          blen, cyc, n_mismatch, samples_checked;
	integer      seed;

	spfe_host_model u_host (.sclk, .cs_n, .si, .dualUpperBitPin);
	spfe_ctrl #(.BYTE_PROG_CYC(BP), .PAGE_PROG_CYC(PP), .BLOCK_ERASE_CYC(50),
		.FULL_ERASE_CYC(80)) u_dut (.core_clk, .rst_n, .sclk, .cs_n, .si,
		.dualUpperBitPin, .writeEnableSet, .sectorProtect, .sectorLock, .memFault,
		.busy, .writeEnableLatch, .programEraseErrorFlag, .memStrobe, .memOp,
		.memAddr, .memData);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkState(input logic [2:0] x);
		@(negedge core_clk);
		chk({busy, writeEnableLatch, programEraseErrorFlag}, x);
		@(posedge core_clk);
	endtask : chkState

	task automatic ex(spfe_memop_t op, logic [23:0] ad, logic [7:0] d, logic [23:0] m);
		expQ.push_back(spfe_exp_t'{op, ad & m, d, m});
	endtask : ex

	task automatic wen();
		writeEnableSet <= 1'b1;
		@(posedge core_clk);
		writeEnableSet <= 1'b0;
		@(negedge core_clk);
		chk(writeEnableLatch, 1'b1);
		@(posedge core_clk);
	endtask : wen

	task automatic run(input logic [7:0] b[$], input int x, input logic dual);
		u_host.frame(b, x, dual);
		for (int i = 0; i < 12 && busy !== 1'b1; i++)
			@(negedge core_clk);
		for (blen = 0; blen < 3000 && busy === 1'b1; blen++)
			@(negedge core_clk);
		repeat (6) @(posedge core_clk);
	endtask : run

	task automatic abort(input logic [39:0] b, input int n, input int x, input logic p,
		input logic l);
		q = {};
		for (int i = 0; i < n; i++)
			q.push_back(b[39 - 8 * i -: 8]);
		sectorProtect[3] <= p;
		sectorLock[3] <= l;
		wen();
		run(q, x, 0);
		chkState(3'b000);
	endtask : abort

	// Sampled on the falling edge so that registered outputs have settled.
	always @(negedge core_clk) begin
		if (memStrobe === 1'b1) begin
			e = '1;
			if (expQ.size() > 0)
				e = expQ.pop_front();
			gd = (e.op == SPFE_MEM_PROG) ? memData : 8'h00;
			chk({memOp, memAddr & e.m, gd}, {e.op, e.a, e.d});
		end
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	initial begin
		seed = 32'hd3ac_1725;
		rst_n = 1'b0;
		writeEnableSet = 1'b0;
		memFault = 1'b0;
		sectorProtect = '0;
		sectorLock = '0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chkState(3'b000);
		q = {8'h20, 8'h00, 8'h00, 8'h00};
		run(q, 0, 0);
		chkState(3'b000);
		wen();
		q = {8'h02, 8'h00, 8'h00, 8'hfe};
		repeat (3) q.push_back(8'($random(seed)));
		ex(SPFE_MEM_PROG, 24'h00_0000, q[6], '1);
		ex(SPFE_MEM_PROG, 24'h00_00fe, q[4], '1);
		ex(SPFE_MEM_PROG, 24'h00_00ff, q[5], '1);
		run(q, 0, 0);
		chk(blen >= PP, 1'b1);
		chkState(3'b000);
		$display("end page wrap");
		wen();
		a = {8'h05, 16'($random(seed))};
		v = 8'($random(seed));
		q = {8'ha2, a[23:16], a[15:8], a[7:0], v};
		ex(SPFE_MEM_PROG, a, v, '1);
		memFault <= 1'b1;
		run(q, 0, 1);
		memFault <= 1'b0;
		chk(blen >= BP && blen < PP, 1'b1);
		chkState(3'b001);
		$display("end dual byte");
		wen();
		q = {8'h02, 8'h01, 8'h23, 8'h00};
		repeat (300) q.push_back(8'($random(seed)));
		for (int o = 0; o < 256; o++)
			ex(SPFE_MEM_PROG, {16'h0123, 8'(o)}, q[4 + ((o < 44) ? o + 256 : o)], '1);
		run(q, 0, 0);
		chkState(3'b000);
		$display("end long page");
		for (int k = 0; k < 5; k++) begin
			a = 24'($random(seed)) & 24'h1f_ffff;
			wen();
			memFault <= (k == 3);
			ex(spfe_memop_t'(k < 3 ? k + 1 : 4), a, 8'h00, EMSK[k]);
			q = {EOPC[k], a[23:16], a[15:8], a[7:0], 8'h5a};
			if (k > 2)
				q = {EOPC[k], 8'h5a};
			run(q, 0, 0);
			memFault <= 1'b0;
			chkState({2'b00, k == 3});
		end
		$display("end erases");
		abort(40'h02_0300_1000, 4, 0, 0, 0);
		abort(40'h02_0300_1055, 5, 3, 0, 0);
		abort(40'h02_0310_5500, 5, 0, 1, 0);
		abort(40'h02_0310_5500, 5, 0, 0, 1);
		abort(40'hd8_0300_0000, 3, 0, 0, 0);
		abort(40'h20_0300_0000, 4, 5, 0, 0);
		abort(40'h52_0300_0000, 4, 0, 1, 0);
		abort(40'h60_0000_0000, 1, 2, 0, 0);
		abort(40'hc7_0000_0000, 1, 0, 0, 1);
		$display("end aborts");
		chk(expQ.size(), 0);
		print_verdict();
	end
endmodule : test_spfe_ctrl
